// ### psr_pkg.sv
// shared constants and types for the strapped register slave and its bus master
`default_nettype none
package psr_pkg;

  // ----------------------------------------------------------------
  // strap decoding
  // ----------------------------------------------------------------
  localparam logic [1:0] LVL_LOW = 2'h0;
  localparam logic [1:0] LVL_FLOAT = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;
  localparam logic [6:0] ADDR_BASE = 7'h08;
  localparam logic [6:0] STRAP2_WEIGHT = 7'h09;
  localparam logic [6:0] STRAP1_WEIGHT = 7'h03;

  // ----------------------------------------------------------------
  // byte framing
  // ----------------------------------------------------------------
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic RW_WRITE = 1'b0;
  localparam logic RW_READ = 1'b1;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ = 200000;
  localparam int SCL_MAX_KHZ = 3400;
  localparam int QUARTER_CYC = (CLK_KHZ + 4 * SCL_MAX_KHZ - 1) / (4 * SCL_MAX_KHZ);

  // ----------------------------------------------------------------
  // state encodings
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    SL_IDLE = 4'h0,
    SL_ADDR = 4'h1,
    SL_ADDR_ACK = 4'h3,
    SL_REG = 4'h2,
    SL_REG_ACK = 4'h6,
    SL_DATA = 4'h7,
    SL_DATA_ACK = 4'h5,
    SL_TX = 4'h4,
    SL_TX_ACK = 4'hc,
    SL_IGNORE = 4'hd
  } psr_slave_state_t;

  typedef enum logic [2:0] {
    MS_IDLE = 3'h0,
    MS_START = 3'h1,
    MS_WBYTE = 3'h3,
    MS_RBYTE = 3'h2,
    MS_STOP = 3'h6
  } psr_master_state_t;

endpackage
`default_nettype wire

// ### psr_bus_if.sv
// two-wire bus between master and slave, open-drain levels resolved here
`default_nettype none
interface psr_bus_if;
  logic m_scl_oe;
  logic m_sda_oe;
  logic s_sda_oe;
  logic scl;
  logic sda;

  // ----------------------------------------------------------------
  // wired-and with pull-ups: any enable pulls the line low
  // ----------------------------------------------------------------
  assign scl = ~m_scl_oe;
  assign sda = ~(m_sda_oe | s_sda_oe);

  modport master (output m_scl_oe, output m_sda_oe, input scl, input sda);
  modport slave (output s_sda_oe, input scl, input sda);
endinterface
`default_nettype wire

// ### psr_slave.sv
// strapped-address single-register slave
// Contract
// - one bus address, picked by three straps
// - each strap decodes low, floating or high
// - address is 8 + 9*s2 + 3*s1 + s0
// - slave only: register write and read
// - master starts, sends address with write bit
// - write: register, data, each acked, then stop
// - read: address, register, then repeated start
// - resend address with read bit, release data
// - slave sends byte, master acks, stops
// - data line only pulled low, never driven
// - keeps up with high-speed bus rates
`default_nettype none
module psr_slave (
  input wire logic clk_sys,
  input wire logic rst_n,
  psr_bus_if.slave bus,
  input wire logic [1:0] addr_strap_0,
  input wire logic [1:0] addr_strap_1,
  input wire logic [1:0] addr_strap_2,
  output logic [6:0] dev_addr,
  output logic addr_valid,
  output logic [7:0] reg_sel,
  output logic [7:0] wr_data,
  output logic wr_strobe,
  output logic rd_strobe,
  input wire logic [7:0] rd_data
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  psr_pkg::psr_slave_state_t state;
  psr_pkg::psr_slave_state_t next_state;
  logic scl_q;
  logic sda_q;
  logic [7:0] shift;
  logic [3:0] cnt;
  logic rw;
  logic sda_oe;
  logic next_scl_q;
  logic next_sda_q;
  logic [7:0] next_shift;
  logic [3:0] next_cnt;
  logic next_rw;
  logic next_sda_oe;
  logic [6:0] next_dev_addr;
  logic next_addr_valid;
  logic [7:0] next_reg_sel;
  logic [7:0] next_wr_data;
  logic next_wr_strobe;
  logic next_rd_strobe;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  // ----------------------------------------------------------------
  // strap level to digit
  // ----------------------------------------------------------------
  function automatic logic [6:0] strap_digit(input logic [1:0] lvl);
    logic [6:0] d;
    case (lvl)
      psr_pkg::LVL_LOW: d = 7'h00;
      psr_pkg::LVL_HIGH: d = 7'h02;
      default: d = 7'h01;
    endcase
    return d;
  endfunction

  // ----------------------------------------------------------------
  // bus events, sampled every system clock
  // ----------------------------------------------------------------
  // edge detection on the 200 MHz clock resolves high-speed bit times
  assign scl_rise = bus.scl & ~scl_q;
  assign scl_fall = ~bus.scl & scl_q;
  assign start_cond = scl_q & bus.scl & sda_q & ~bus.sda;
  assign stop_cond = scl_q & bus.scl & ~sda_q & bus.sda;

  // only ever pulls low; the pull-up makes the high level
  assign bus.s_sda_oe = sda_oe;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    next_scl_q = bus.scl;
    next_sda_q = bus.sda;
    next_shift = shift;
    next_cnt = cnt;
    next_rw = rw;
    next_sda_oe = sda_oe;
    next_dev_addr = dev_addr;
    next_addr_valid = addr_valid;
    next_reg_sel = reg_sel;
    next_wr_data = wr_data;
    next_wr_strobe = 1'b0;
    next_rd_strobe = 1'b0;
    // straps are caught once, on the first edge after reset release
    if (!addr_valid)
    begin
      next_dev_addr = psr_pkg::ADDR_BASE
        + 7'(psr_pkg::STRAP2_WEIGHT * strap_digit(addr_strap_2))
        + 7'(psr_pkg::STRAP1_WEIGHT * strap_digit(addr_strap_1))
        + strap_digit(addr_strap_0);
      next_addr_valid = 1'b1;
    end
    if (stop_cond)
    begin
      next_state = psr_pkg::SL_IDLE;
      next_sda_oe = 1'b0;
    end
    else if (start_cond)
    begin
      // start and repeated start both reopen the address phase
      next_state = psr_pkg::SL_ADDR;
      next_cnt = 4'h0;
      next_sda_oe = 1'b0;
    end
    else
    begin
      case (state)
        psr_pkg::SL_ADDR, psr_pkg::SL_REG, psr_pkg::SL_DATA:
        begin
          if (scl_rise && cnt < psr_pkg::ACK_BIT)
          begin
            next_shift = {shift[6:0], bus.sda};
            next_cnt = cnt + 4'h1;
          end
          else if (scl_fall && cnt == psr_pkg::ACK_BIT)
          begin
            next_cnt = 4'h0;
            if (state == psr_pkg::SL_ADDR)
            begin
              if (addr_valid && shift[7:1] == dev_addr)
              begin
                next_rw = shift[0];
                next_state = psr_pkg::SL_ADDR_ACK;
                next_sda_oe = 1'b1;
              end
              else
              begin
                next_state = psr_pkg::SL_IGNORE;
              end
            end
            else if (state == psr_pkg::SL_REG)
            begin
              next_reg_sel = shift;
              next_state = psr_pkg::SL_REG_ACK;
              next_sda_oe = 1'b1;
            end
            else
            begin
              next_wr_data = shift;
              next_wr_strobe = 1'b1;
              next_state = psr_pkg::SL_DATA_ACK;
              next_sda_oe = 1'b1;
            end
          end
        end
        psr_pkg::SL_ADDR_ACK:
        begin
          if (scl_fall)
          begin
            if (rw == psr_pkg::RW_READ)
            begin
              // first data bit goes out right as the ack ends
              next_shift = rd_data;
              next_rd_strobe = 1'b1;
              next_sda_oe = ~rd_data[7];
              next_cnt = 4'h0;
              next_state = psr_pkg::SL_TX;
            end
            else
            begin
              next_sda_oe = 1'b0;
              next_state = psr_pkg::SL_REG;
            end
          end
        end
        psr_pkg::SL_REG_ACK:
        begin
          if (scl_fall)
          begin
            next_sda_oe = 1'b0;
            next_state = psr_pkg::SL_DATA;
          end
        end
        psr_pkg::SL_DATA_ACK:
        begin
          // one data byte per write; later bytes are left unacked
          if (scl_fall)
          begin
            next_sda_oe = 1'b0;
            next_state = psr_pkg::SL_IGNORE;
          end
        end
        psr_pkg::SL_TX:
        begin
          if (scl_rise)
          begin
            next_cnt = cnt + 4'h1;
          end
          else if (scl_fall)
          begin
            if (cnt == psr_pkg::ACK_BIT)
            begin
              next_sda_oe = 1'b0;
              next_state = psr_pkg::SL_TX_ACK;
            end
            else
            begin
              next_shift = {shift[6:0], 1'b0};
              next_sda_oe = ~shift[6];
            end
          end
        end
        psr_pkg::SL_TX_ACK:
        begin
          // single-byte read: the master's ack closes the byte
          if (scl_fall)
          begin
            next_state = psr_pkg::SL_IGNORE;
          end
        end
        psr_pkg::SL_IDLE, psr_pkg::SL_IGNORE:
        begin
          next_sda_oe = 1'b0;
        end
        default:
        begin
          next_state = psr_pkg::SL_IDLE;
          next_sda_oe = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state <= psr_pkg::SL_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      shift <= 8'h00;
      cnt <= 4'h0;
      rw <= psr_pkg::RW_WRITE;
      sda_oe <= 1'b0;
      dev_addr <= 7'h00;
      addr_valid <= 1'b0;
      reg_sel <= 8'h00;
      wr_data <= 8'h00;
      wr_strobe <= 1'b0;
      rd_strobe <= 1'b0;
    end
    else
    begin
      state <= next_state;
      scl_q <= next_scl_q;
      sda_q <= next_sda_q;
      shift <= next_shift;
      cnt <= next_cnt;
      rw <= next_rw;
      sda_oe <= next_sda_oe;
      dev_addr <= next_dev_addr;
      addr_valid <= next_addr_valid;
      reg_sel <= next_reg_sel;
      wr_data <= next_wr_data;
      wr_strobe <= next_wr_strobe;
      rd_strobe <= next_rd_strobe;
    end
  end

endmodule
`default_nettype wire

// ### psr_master.sv
// bus master issuing single-register writes and reads
`default_nettype none
module psr_master #(
  parameter int QUARTER_CYC = psr_pkg::QUARTER_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  psr_bus_if.master bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic [6:0] cmd_dev,
  input wire logic [7:0] cmd_reg,
  input wire logic [7:0] cmd_wdata,
  output logic resp_valid,
  output logic resp_nack,
  output logic [7:0] resp_data
);

  if (QUARTER_CYC < 2 || QUARTER_CYC > 255)
  begin : g_bad_quarter
    $error("QUARTER_CYC must lie in 2..255");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam logic [7:0] QLAST = 8'(QUARTER_CYC - 1);
  psr_pkg::psr_master_state_t state;
  psr_pkg::psr_master_state_t next_state;
  logic [7:0] qcnt;
  logic [1:0] phase;
  logic [3:0] bitn;
  logic [1:0] byte_idx;
  logic [7:0] shift;
  logic rd;
  logic [6:0] dev;
  logic [7:0] regn;
  logic [7:0] wdata;
  logic nack;
  logic [7:0] next_qcnt;
  logic [1:0] next_phase;
  logic [3:0] next_bitn;
  logic [1:0] next_byte_idx;
  logic [7:0] next_shift;
  logic next_rd;
  logic [6:0] next_dev;
  logic [7:0] next_regn;
  logic [7:0] next_wdata;
  logic next_nack;
  logic next_resp_valid;
  logic next_resp_nack;
  logic [7:0] next_resp_data;
  logic tick;

  assign tick = (qcnt == QLAST);
  assign cmd_ready = (state == psr_pkg::MS_IDLE);

  // ----------------------------------------------------------------
  // line drive: enables only pull low
  // ----------------------------------------------------------------
  always_comb
  begin
    case (state)
      psr_pkg::MS_START:
      begin
        bus.m_scl_oe = (phase == 2'h0);
        bus.m_sda_oe = phase[1];
      end
      psr_pkg::MS_WBYTE:
      begin
        bus.m_scl_oe = ~phase[1];
        bus.m_sda_oe = (bitn < psr_pkg::ACK_BIT) & ~shift[7];
      end
      psr_pkg::MS_RBYTE:
      begin
        bus.m_scl_oe = ~phase[1];
        bus.m_sda_oe = (bitn == psr_pkg::ACK_BIT);
      end
      psr_pkg::MS_STOP:
      begin
        bus.m_scl_oe = (phase == 2'h0);
        bus.m_sda_oe = ~phase[1];
      end
      default:
      begin
        bus.m_scl_oe = 1'b0;
        bus.m_sda_oe = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    next_qcnt = tick ? 8'h00 : qcnt + 8'h01;
    next_phase = tick ? phase + 2'h1 : phase;
    next_bitn = bitn;
    next_byte_idx = byte_idx;
    next_shift = shift;
    next_rd = rd;
    next_dev = dev;
    next_regn = regn;
    next_wdata = wdata;
    next_nack = nack;
    next_resp_valid = 1'b0;
    next_resp_nack = resp_nack;
    next_resp_data = resp_data;
    if (state == psr_pkg::MS_IDLE)
    begin
      next_qcnt = 8'h00;
      next_phase = 2'h0;
      if (cmd_valid)
      begin
        next_rd = cmd_read;
        next_dev = cmd_dev;
        next_regn = cmd_reg;
        next_wdata = cmd_wdata;
        next_nack = 1'b0;
        next_byte_idx = 2'h0;
        next_state = psr_pkg::MS_START;
      end
    end
    else if (tick && phase == 2'h2)
    begin
      if (state == psr_pkg::MS_WBYTE && bitn == psr_pkg::ACK_BIT)
      begin
        next_nack = nack | bus.sda;
      end
      else if (state == psr_pkg::MS_RBYTE && bitn < psr_pkg::ACK_BIT)
      begin
        next_shift = {shift[6:0], bus.sda};
      end
    end
    else if (tick && phase == 2'h3)
    begin
      case (state)
        psr_pkg::MS_START:
        begin
          next_bitn = 4'h0;
          next_state = psr_pkg::MS_WBYTE;
          if (byte_idx == 2'h2)
          begin
            next_shift = {dev, psr_pkg::RW_READ};
            next_byte_idx = 2'h3;
          end
          else
          begin
            next_shift = {dev, psr_pkg::RW_WRITE};
          end
        end
        psr_pkg::MS_WBYTE:
        begin
          if (bitn < psr_pkg::ACK_BIT)
          begin
            next_bitn = bitn + 4'h1;
            next_shift = {shift[6:0], 1'b0};
          end
          else
          begin
            next_bitn = 4'h0;
            if (nack)
            begin
              next_state = psr_pkg::MS_STOP;
            end
            else if (byte_idx == 2'h0)
            begin
              next_shift = regn;
              next_byte_idx = 2'h1;
            end
            else if (byte_idx == 2'h1 && !rd)
            begin
              next_shift = wdata;
              next_byte_idx = 2'h2;
            end
            else if (byte_idx == 2'h1)
            begin
              next_byte_idx = 2'h2;
              next_state = psr_pkg::MS_START;
            end
            else if (byte_idx == 2'h3)
            begin
              next_state = psr_pkg::MS_RBYTE;
            end
            else
            begin
              next_state = psr_pkg::MS_STOP;
            end
          end
        end
        psr_pkg::MS_RBYTE:
        begin
          if (bitn < psr_pkg::ACK_BIT)
          begin
            next_bitn = bitn + 4'h1;
          end
          else
          begin
            next_resp_data = shift;
            next_state = psr_pkg::MS_STOP;
          end
        end
        psr_pkg::MS_STOP:
        begin
          next_resp_valid = 1'b1;
          next_resp_nack = nack;
          next_state = psr_pkg::MS_IDLE;
        end
        default:
        begin
          next_state = psr_pkg::MS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state <= psr_pkg::MS_IDLE;
      qcnt <= 8'h00;
      phase <= 2'h0;
      bitn <= 4'h0;
      byte_idx <= 2'h0;
      shift <= 8'h00;
      rd <= 1'b0;
      dev <= 7'h00;
      regn <= 8'h00;
      wdata <= 8'h00;
      nack <= 1'b0;
      resp_valid <= 1'b0;
      resp_nack <= 1'b0;
      resp_data <= 8'h00;
    end
    else
    begin
      state <= next_state;
      qcnt <= next_qcnt;
      phase <= next_phase;
      bitn <= next_bitn;
      byte_idx <= next_byte_idx;
      shift <= next_shift;
      rd <= next_rd;
      dev <= next_dev;
      regn <= next_regn;
      wdata <= next_wdata;
      nack <= next_nack;
      resp_valid <= next_resp_valid;
      resp_nack <= next_resp_nack;
      resp_data <= next_resp_data;
    end
  end

endmodule
`default_nettype wire

// ### psr_bus_sva.sv
// concurrent checks on the two-wire bus joining master and slave
`default_nettype none
module psr_bus_sva (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic m_scl_oe,
  input wire logic m_sda_oe,
  input wire logic s_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev_scl;
  logic prev_sda;
  logic seen_start;
  logic [4:0] bit_cnt;
  logic next_seen_start;
  logic [4:0] next_bit_cnt;
  logic start_cond;
  logic stop_cond;

  // ----------------------------------------------------------------
  // start, stop and bit tracking
  // ----------------------------------------------------------------
  assign start_cond = prev_scl & scl & prev_sda & ~sda;
  assign stop_cond = prev_scl & scl & ~prev_sda & sda;

  always_comb
  begin
    next_seen_start = seen_start | start_cond;
    next_bit_cnt = bit_cnt;
    if (start_cond)
    begin
      next_bit_cnt = 5'h00;
    end
    else if (scl && !prev_scl && bit_cnt != 5'h1f)
    begin
      next_bit_cnt = bit_cnt + 5'h01;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      prev_scl <= 1'b1;
      prev_sda <= 1'b1;
      seen_start <= 1'b0;
      bit_cnt <= 5'h1f;
    end
    else
    begin
      prev_scl <= scl;
      prev_sda <= sda;
      seen_start <= next_seen_start;
      bit_cnt <= next_bit_cnt;
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_reset_release;
    @(posedge clk_sys) !rst_n |=> (!m_scl_oe && !m_sda_oe && !s_sda_oe);
  endproperty
  a_reset_release: assert property (p_reset_release)
    else $error("bus line held low after reset");

  property p_slave_edge;
    @(posedge clk_sys) disable iff (!rst_n) $changed(s_sda_oe) |-> (!scl && !$past(scl));
  endproperty
  a_slave_edge: assert property (p_slave_edge)
    else $error("slave moved data line while clock high");

  property p_ack_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      $rose(s_sda_oe) |-> (s_sda_oe throughout (##[1:300] $fell(scl)));
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("slave released data line before clock fell");

  property p_addr_ack;
    @(posedge clk_sys) disable iff (!rst_n)
      (scl && prev_scl && s_sda_oe && bit_cnt < 5'h0a) |-> bit_cnt == 5'h09;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("slave drove data line inside address byte");

  property p_data_ack;
    @(posedge clk_sys) disable iff (!rst_n)
      (scl && prev_scl && s_sda_oe && bit_cnt > 5'h12) |-> bit_cnt == 5'h1b;
  endproperty
  a_data_ack: assert property (p_data_ack)
    else $error("slave drove data line after write data ack");

  property p_stop_quiet;
    @(posedge clk_sys) disable iff (!rst_n) stop_cond |=> (!s_sda_oe)[*8];
  endproperty
  a_stop_quiet: assert property (p_stop_quiet)
    else $error("slave active after stop");

  property p_idle_quiet;
    @(posedge clk_sys) disable iff (!rst_n) !seen_start |-> !s_sda_oe;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("slave drove data line before any start");

  property p_start_free;
    @(posedge clk_sys) disable iff (!rst_n) start_cond |-> !s_sda_oe;
  endproperty
  a_start_free: assert property (p_start_free)
    else $error("slave pulled data line at a start");
endmodule
`default_nettype wire

// ### pin_strapped_i2c_register_slave_tb.sv
// self-checking bench: master and slave joined over the two-wire bus
`default_nettype none
module pin_strapped_i2c_register_slave_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] DEV = 7'h1d;
  logic clk_sys;
  logic rst_n;
  logic [1:0] strap_0, strap_1, strap_2;
  logic cmd_valid, cmd_ready, cmd_read, resp_valid, resp_nack;
  logic [6:0] cmd_dev, dev_addr;
  logic [7:0] cmd_reg, cmd_wdata, resp_data, reg_sel, wr_data, rd_data;
  logic addr_valid, wr_strobe, rd_strobe, prev_scl, prev_sda, wire_ack;
  logic [7:0] wr_cnt, rd_cnt, mon_sh, wire_addr;
  logic [7:0] mem [256];
  int mon_cnt;
  int failures;
  int samples_checked;

  psr_bus_if bus_a ();
  psr_master #(.QUARTER_CYC(2)) psr_master_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .bus(bus_a), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read),
    .cmd_dev(cmd_dev), .cmd_reg(cmd_reg), .cmd_wdata(cmd_wdata), .resp_valid(resp_valid),
    .resp_nack(resp_nack), .resp_data(resp_data));
  psr_slave psr_slave_inst (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus_a),
    .addr_strap_0(strap_0), .addr_strap_1(strap_1), .addr_strap_2(strap_2),
    .dev_addr(dev_addr), .addr_valid(addr_valid), .reg_sel(reg_sel), .wr_data(wr_data),
    .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data));
  psr_bus_sva psr_bus_sva_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .m_scl_oe(bus_a.m_scl_oe), .m_sda_oe(bus_a.m_sda_oe), .s_sda_oe(bus_a.s_sda_oe),
    .scl(bus_a.scl), .sda(bus_a.sda));

  // ----------------------------------------------------------------
  // register file behind the slave and wire monitor
  // ----------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (wr_strobe)
    begin
      mem[reg_sel] <= wr_data;
      wr_cnt <= wr_cnt + 8'h01;
    end
    if (rd_strobe)
    begin
      rd_cnt <= rd_cnt + 8'h01;
    end
    rd_data <= mem[reg_sel];
    prev_scl <= bus_a.scl;
    prev_sda <= bus_a.sda;
    if (prev_scl && bus_a.scl && prev_sda && !bus_a.sda)
    begin
      mon_cnt <= 0;
    end
    else if (bus_a.scl && !prev_scl)
    begin
      mon_cnt <= mon_cnt + 1;
      mon_sh <= {mon_sh[6:0], bus_a.sda};
      if (mon_cnt == 7)
      begin
        wire_addr <= {mon_sh[6:0], bus_a.sda};
      end
      if (mon_cnt == 8)
      begin
        wire_ack <= bus_a.sda;
      end
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR t=%0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic do_reset(input logic [1:0] s2, input logic [1:0] s1, input logic [1:0] s0,
                          input int n);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    strap_2 <= s2;
    strap_1 <= s1;
    strap_0 <= s0;
    repeat (n) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
  endtask

  task automatic do_cmd(input logic rd, input logic [6:0] dev, input logic [7:0] rg,
                        input logic [7:0] wd);
    int n;
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_read <= rd;
    cmd_dev <= dev;
    cmd_reg <= rg;
    cmd_wdata <= wd;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (cmd_ready !== 1'b1 && n < 50);
    cmd_valid <= 1'b0;
    n = 0;
    while (resp_valid !== 1'b1 && n < 3000)
    begin
      @(posedge clk_sys);
      n++;
    end
    check({7'h00, resp_valid}, 8'h01, "response");
  endtask

  task automatic write_chk(input logic [7:0] rg, input logic [7:0] wd);
    logic [7:0] c0;
    c0 = wr_cnt;
    do_cmd(1'b0, DEV, rg, wd);
    check(wr_cnt, c0 + 8'h01, "write strobes");
    check(reg_sel, rg, "register number");
    check(wr_data, wd, "write data");
    check({7'h00, resp_nack}, 8'h00, "write nack");
    check(wire_addr, {DEV, 1'b0}, "wire address byte");
    check({7'h00, wire_ack}, 8'h00, "wire address ack");
  endtask

  task automatic read_chk(input logic [7:0] rg, input logic [7:0] exp);
    logic [7:0] c0;
    c0 = rd_cnt;
    do_cmd(1'b1, DEV, rg, 8'h00);
    check(resp_data, exp, "read data");
    check({7'h00, resp_nack}, 8'h00, "read nack");
    check(reg_sel, rg, "read register");
    check(wire_addr, {DEV, 1'b1}, "wire read address");
    check({7'h00, wire_ack}, 8'h00, "wire read ack");
    check(rd_cnt, c0 + 8'h01, "read strobes");
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_straps();
    for (int a = 0; a < 3; a++)
      for (int b = 0; b < 3; b++)
        for (int c = 0; c < 3; c++)
        begin
          do_reset(a[1:0], b[1:0], c[1:0], 2);
          check({1'b0, dev_addr}, 8'h08 + 8'(9 * a + 3 * b + c), "strap address");
          check({7'h00, addr_valid}, 8'h01, "address valid");
        end
    do_reset(2'h3, 2'h3, 2'h3, 2);
    check({1'b0, dev_addr}, 8'h15, "open strap code");
    do_reset(2'h2, 2'h1, 2'h0, 4);
    check({1'b0, dev_addr}, {1'b0, DEV}, "test address");
    check({6'h00, bus_a.scl, bus_a.sda}, 8'h03, "idle lines");
    $display("test straps done");
  endtask

  task automatic t_write_read();
    write_chk(8'h00, 8'h3c);
    write_chk(8'hff, 8'hc3);
    read_chk(8'hff, 8'hc3);
    read_chk(8'h00, 8'h3c);
    $display("test write and read done");
  endtask

  task automatic t_nack();
    logic [7:0] c0;
    c0 = wr_cnt;
    do_cmd(1'b0, DEV ^ 7'h01, 8'h10, 8'h77);
    check({7'h00, resp_nack}, 8'h01, "foreign write nack");
    check(wr_cnt, c0, "foreign write strobes");
    check({7'h00, wire_ack}, 8'h01, "foreign wire ack");
    check(wire_addr, {DEV ^ 7'h01, 1'b0}, "foreign wire address");
    do_cmd(1'b1, 7'h22, 8'hff, 8'h00);
    check({7'h00, resp_nack}, 8'h01, "foreign read nack");
    read_chk(8'hff, 8'hc3);
    $display("test foreign address done");
  endtask

  task automatic t_abort();
    logic [7:0] c0;
    c0 = wr_cnt;
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_read <= 1'b0;
    cmd_dev <= DEV;
    cmd_reg <= 8'h42;
    cmd_wdata <= 8'h99;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    repeat (100) @(posedge clk_sys);
    do_reset(2'h2, 2'h1, 2'h0, 2);
    check({6'h00, bus_a.scl, bus_a.sda}, 8'h03, "lines after abort");
    check(wr_cnt, c0, "aborted write strobes");
    write_chk(8'h42, 8'h99);
    read_chk(8'h42, 8'h99);
    $display("test abort done");
  endtask

  task automatic end_of_test();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
    begin
      $display("Test passed");
    end
    else
    begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  initial
  begin
    rst_n = 1'b0;
    strap_0 = 2'h0;
    strap_1 = 2'h0;
    strap_2 = 2'h0;
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_dev = 7'h00;
    cmd_reg = 8'h00;
    cmd_wdata = 8'h00;
    rd_data = 8'h00;
    wr_cnt = 8'h00;
    rd_cnt = 8'h00;
    prev_scl = 1'b1;
    prev_sda = 1'b1;
    mon_cnt = 0;
    mon_sh = 8'h00;
    wire_addr = 8'h00;
    wire_ack = 1'b1;
    failures = 0;
    samples_checked = 0;
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'h5a;
    repeat (4) @(posedge clk_sys);
    t_straps();
    t_write_read();
    t_nack();
    t_abort();
    end_of_test();
  end

  initial
  begin
    repeat (40000) @(posedge clk_sys);
    failures++;
    $display("ERROR t=%0t watchdog expired", $time);
    end_of_test();
  end
endmodule
`default_nettype wire
